// file: hw/bmoc_top.v
// backup mode output forcing, chip-select gating and power-fail warning
`timescale 1ns/10ps
`default_nettype none
`include "bmoc_consts.vh"
module bmoc_top #(
	parameter [31:0] WD_SHORT_CYC = `BMOC_WD_SHORT_CYC,
	parameter [31:0] WD_LONG_CYC = `BMOC_WD_LONG_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// digitised comparator results
	input wire supply_low,
	input wire battery_near,
	input wire warn_below_ref,
	// processor side
	input wire cs_in_n,
	input wire kick_in,
	input wire timebase_in,
	input wire timebase_select,
	// outputs
	output reg cs_out_n,
	output reg backup_active_out,
	output reg supply_warn_n,
	output reg reset_n,
	output reg reset_hi,
	output reg undervolt_n,
	output reg timeout_flag_n
);
	// ****************************************
	// operating modes
	// ****************************************
	localparam [2:0] MODE_RUN = 3'h1;
	localparam [2:0] MODE_LOW = 3'h2;
	localparam [2:0] MODE_BACKUP = 3'h4;
	wire [2:0] mode;
	// backup outranks a low supply: the battery already holds the rail
	function [2:0] mode_of;
		input low;
		input near;
		begin
			if (near)
				mode_of = MODE_BACKUP;
			else if (low)
				mode_of = MODE_LOW;
			else
				mode_of = MODE_RUN;
		end
	endfunction
	// sense comparator has no hysteresis, so the level passes through, only inverted
	function warn_level;
		input below;
		begin
			warn_level = !below;
		end
	endfunction
	// switchover hysteresis lives in the analog comparator, not here
	assign mode = mode_of(supply_low, battery_near);
	// ****************************************
	// watchdog
	// ****************************************
	wire wd_run;
	wire wd_expired;
	wire kick_edge;
	wire long_sel;
	reg kick_prev_q;
	reg kick_prev_d;
	// timer runs only on a valid supply; a kick level left changed in backup counts as a kick once it runs again
	assign wd_run = (mode == MODE_RUN);
	// any level change counts as a kick, in either direction
	assign kick_edge = wd_run && (kick_in != kick_prev_q);
	// select pin only matters while the timer counts
	assign long_sel = wd_run ? timebase_select : 1'b1;
	// timebase_in is left unread: no external oscillator is modelled
	always @*
	begin
		kick_prev_d = kick_prev_q;
		if (wd_run)
			kick_prev_d = kick_in;
	end
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			kick_prev_q <= 1'b0;
		else
			kick_prev_q <= kick_prev_d;
	end
	// counter clears on a kick or whenever the timer is stopped
	bmoc_wdog #(
		.SHORT_CYC(WD_SHORT_CYC),
		.LONG_CYC(WD_LONG_CYC)
	) bmoc_wdog_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(wd_run),
		.long_sel(long_sel),
		.kick(kick_edge),
		.expired_q(wd_expired)
	);
	// ****************************************
	// output next values
	// ****************************************
	reg cs_out_n_d;
	reg backup_active_d;
	reg supply_warn_n_d;
	reg reset_n_d;
	reg reset_hi_d;
	reg undervolt_n_d;
	reg timeout_flag_n_d;
	// defaults are the safe state: memory shut, reset held
	always @*
	begin
		cs_out_n_d = 1'b1;
		backup_active_d = 1'b0;
		supply_warn_n_d = 1'b1;
		reset_n_d = 1'b0;
		reset_hi_d = 1'b1;
		undervolt_n_d = 1'b0;
		timeout_flag_n_d = 1'b1;
		case (mode)
			MODE_BACKUP:
			begin
				// backup pins every output to its standby level
				backup_active_d = 1'b1;
				reset_hi_d = 1'b1;
				timeout_flag_n_d = 1'b1;
				cs_out_n_d = 1'b1;
				supply_warn_n_d = 1'b0;
				reset_n_d = 1'b0;
				undervolt_n_d = 1'b0;
			end
			MODE_LOW:
			begin
				backup_active_d = 1'b0;
				// writes blocked whatever the processor asks for
				cs_out_n_d = 1'b1;
				supply_warn_n_d = warn_level(warn_below_ref);
				reset_n_d = 1'b0;
				reset_hi_d = 1'b1;
				undervolt_n_d = 1'b0;
				// timeout flag is released while the supply is low
				timeout_flag_n_d = 1'b1;
			end
			MODE_RUN:
			begin
				backup_active_d = 1'b0;
				cs_out_n_d = cs_in_n;
				supply_warn_n_d = warn_level(warn_below_ref);
				// a lapsed watchdog pulls reset until the next kick
				reset_n_d = !wd_expired;
				reset_hi_d = wd_expired;
				undervolt_n_d = 1'b1;
				timeout_flag_n_d = !wd_expired;
			end
			default:
			begin
				// no mode decoded: keep memory shut and reset asserted
				cs_out_n_d = 1'b1;
				reset_n_d = 1'b0;
				reset_hi_d = 1'b1;
			end
		endcase
	end
	// one cycle of latency: the trade for flop-driven outputs
	// ****************************************
	// memory gate register
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (!rst_n)
			cs_out_n <= 1'b1;
		else
			cs_out_n <= cs_out_n_d;
	end
	// ****************************************
	// supply status registers
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			backup_active_out <= 1'b0;
			supply_warn_n <= 1'b1;
			undervolt_n <= 1'b0;
		end
		else
		begin
			backup_active_out <= backup_active_d;
			supply_warn_n <= supply_warn_n_d;
			undervolt_n <= undervolt_n_d;
		end
	end
	// ****************************************
	// reset and watchdog registers
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			reset_n <= 1'b0;
			reset_hi <= 1'b1;
			timeout_flag_n <= 1'b1;
		end
		else
		begin
			reset_n <= reset_n_d;
			reset_hi <= reset_hi_d;
			timeout_flag_n <= timeout_flag_n_d;
		end
	end
endmodule // bmoc_top
`default_nettype wire

// file: pkg/bmoc_consts.vh
// constants for the backup mode output control block
`ifndef BMOC_CONSTS_VH
`define BMOC_CONSTS_VH
// watchdog timeout counts, in ref_clk cycles (40 MHz)
`define BMOC_CLK_HZ 40000000
`define BMOC_WD_SHORT_MS 100
`define BMOC_WD_LONG_MS 1600
`define BMOC_WD_SHORT_CYC (`BMOC_CLK_HZ / 1000 * `BMOC_WD_SHORT_MS)
`define BMOC_WD_LONG_CYC (`BMOC_CLK_HZ / 1000 * `BMOC_WD_LONG_MS)
`define BMOC_WD_W 32
`endif

// file: hw/bmoc_wdog.v
// watchdog timer core for the backup mode output control block
`timescale 1ns/10ps
`default_nettype none
module bmoc_wdog #(
	parameter [31:0] SHORT_CYC = 32'h003D_0900,
	parameter [31:0] LONG_CYC = 32'h03D0_9000
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// control
	input wire run,
	input wire long_sel,
	input wire kick,
	// status
	output reg expired_q
);
	reg [31:0] cnt_q;
	wire [31:0] limit;
	assign limit = long_sel ? LONG_CYC : SHORT_CYC;
	// ****************************************
	// timer
	// ****************************************
	always @(posedge ref_clk)
	begin
		if (!rst_n || !run || kick)
		begin
			cnt_q <= 32'h0000_0000;
			expired_q <= 1'b0;
		end
		else if (cnt_q >= limit - 32'h0000_0001)
			expired_q <= 1'b1;
		else
			cnt_q <= cnt_q + 32'h0000_0001;
	end
endmodule // bmoc_wdog
`default_nettype wire

// file: testbench/bmoc_properties.sv
// bmoc checker
`timescale 1ns/10ps
`default_nettype none
module bmoc_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// block inputs
	input wire logic supply_low,
	input wire logic battery_near,
	input wire logic warn_below_ref,
	input wire logic cs_in_n,
	// block outputs
	input wire logic cs_out_n,
	input wire logic backup_active_out,
	input wire logic supply_warn_n,
	input wire logic reset_n,
	input wire logic reset_hi,
	input wire logic undervolt_n,
	input wire logic timeout_flag_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_ex; battery_near ##1 !battery_near; endsequence
	// a sense flip is judged only after two cycles out of backup in a row
	sequence s_tg; !battery_near ##1 (!battery_near && $changed(warn_below_ref)); endsequence
	property p_cs; !battery_near && !supply_low |=> cs_out_n == $past(cs_in_n); endproperty
	a_cs: assert property(p_cs) else $error("cs");
	property p_hi; battery_near |=> reset_hi && timeout_flag_n; endproperty
	a_hi: assert property(p_hi) else $error("hi");
	property p_tg; s_tg |=> $changed(supply_warn_n); endproperty
	a_tg: assert property(p_tg) else $error("tg");
	property p_lo; supply_low|=>cs_out_n; endproperty
	a_lo: assert property(p_lo) else $error("lo");
	property p_bk; battery_near|=>backup_active_out&&cs_out_n; endproperty
	a_bk: assert property(p_bk) else $error("bk");
	property p_pf; battery_near|=>!supply_warn_n; endproperty
	a_pf: assert property(p_pf) else $error("pf");
	property p_wn; !battery_near|=>supply_warn_n!=$past(warn_below_ref); endproperty
	a_wn: assert property(p_wn) else $error("wn");
	property p_ex; s_ex|=>!backup_active_out; endproperty
	a_ex: assert property(p_ex) else $error("ex");
	property p_uv; !battery_near|=>undervolt_n!=$past(supply_low); endproperty
	a_uv: assert property(p_uv) else $error("uv");
	property p_rs; battery_near|=>!reset_n; endproperty
	a_rs: assert property(p_rs) else $error("rs");
	property p_ru; battery_near|=>!undervolt_n; endproperty
	a_ru: assert property(p_ru) else $error("ru");
endmodule // bmoc_chk
`default_nettype wire

// file: testbench/bmoc_ram.sv
// ram select partner
`timescale 1ns/10ps
`default_nettype none
module bmoc_ram (
	// clock
	input wire logic ref_clk,
	// gated select from the block
	input wire logic cs_n,
	// selected-cycle count
	output var int sel = 0
);
	// counts selected cycles; a write while backed up shows here
	always @(posedge ref_clk)
	begin
		if (!cs_n)
			sel <= sel + 1;
	end
endmodule // bmoc_ram
`default_nettype wire

// file: testbench/tb_top.sv
// bmoc bench
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin checked++; if ((a)!==(b)) \
	begin miscompares++; $display("MISMATCH %0t cmp", $time); end end
module tb_top;
	logic ref_clk=0,rst_n=0,supply_low=0,battery_near=0,warn_below_ref=0,cs_in_n=1;
	logic kick_in=0,timebase_in=0,timebase_select=0;
	wire cs_out_n,backup_active_out,supply_warn_n,reset_n,reset_hi,undervolt_n,timeout_flag_n;
	int miscompares=0,checked=0,cyc=0,sel,s;
	// short watchdog keeps the run brief
	bmoc_top #(
		.WD_SHORT_CYC(32'h0000_0014),
		.WD_LONG_CYC(32'h0000_0028)
	) bmoc_top_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.supply_low(supply_low),
		.battery_near(battery_near),
		.warn_below_ref(warn_below_ref),
		.cs_in_n(cs_in_n),
		.kick_in(kick_in),
		.timebase_in(timebase_in),
		.timebase_select(timebase_select),
		.cs_out_n(cs_out_n),
		.backup_active_out(backup_active_out),
		.supply_warn_n(supply_warn_n),
		.reset_n(reset_n),
		.reset_hi(reset_hi),
		.undervolt_n(undervolt_n),
		.timeout_flag_n(timeout_flag_n)
	);
	bmoc_ram bmoc_ram_inst (
		.ref_clk(ref_clk),
		.cs_n(cs_out_n),
		.sel(sel)
	);
	initial forever #12.5 ref_clk=~ref_clk;
	task w;
		repeat (3) @(negedge ref_clk);
	endtask
	task complete_run;
		if (miscompares==0&&checked>0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// about 110 cycles of tests; the ceiling leaves room
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc>300)
		begin
			miscompares++;
			complete_run;
		end
	end
	task t_norm;
		cs_in_n=0;
		w;
		`CHK(cs_out_n,1'b0)
		`CHK(undervolt_n,1'b1)
		`CHK(supply_warn_n,1'b1)
		supply_low=1;
		warn_below_ref=1;
		w;
		`CHK(cs_out_n,1'b1)
		`CHK(undervolt_n,1'b0)
		`CHK(supply_warn_n,1'b0)
		supply_low=0;
		w;
		`CHK(cs_out_n,1'b0)
		`CHK(supply_warn_n,1'b0)
		warn_below_ref=0;
		w;
		`CHK(supply_warn_n,1'b1)
	endtask
	// kick toggled twice in backup: no net edge is left for the exit
	task t_back;
		battery_near=1;
		kick_in=1;
		timebase_select=1;
		timebase_in=1;
		w;
		`CHK(backup_active_out,1'b1)
		`CHK(reset_hi,1'b1)
		`CHK(timeout_flag_n,1'b1)
		`CHK(cs_out_n,1'b1)
		`CHK(supply_warn_n,1'b0)
		`CHK(reset_n,1'b0)
		`CHK(undervolt_n,1'b0)
		s=sel;
		kick_in=0;
		repeat (25) @(negedge ref_clk);
		`CHK(sel,s)
		`CHK(timeout_flag_n,1'b1)
		timebase_select=0;
		timebase_in=0;
		battery_near=0;
		w;
		`CHK(backup_active_out,1'b0)
		repeat (17) @(negedge ref_clk);
		`CHK(timeout_flag_n,1'b1)
		@(negedge ref_clk);
		`CHK(timeout_flag_n,1'b0)
	endtask
	// outside backup a kick clears the flag and the select pin counts
	task t_wdog;
		kick_in=1;
		timebase_select=1;
		repeat (2) @(negedge ref_clk);
		`CHK(timeout_flag_n,1'b1)
		repeat (39) @(negedge ref_clk);
		`CHK(timeout_flag_n,1'b1)
		@(negedge ref_clk);
		`CHK(timeout_flag_n,1'b0)
	endtask
	initial
	begin
		repeat (8) @(negedge ref_clk);
		rst_n=1;
		t_norm;
		t_back;
		t_wdog;
		complete_run;
	end
endmodule // tb_top
bind bmoc_top bmoc_chk bmoc_chk_inst (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.supply_low(supply_low),
	.battery_near(battery_near),
	.warn_below_ref(warn_below_ref),
	.cs_in_n(cs_in_n),
	.cs_out_n(cs_out_n),
	.backup_active_out(backup_active_out),
	.supply_warn_n(supply_warn_n),
	.reset_n(reset_n),
	.reset_hi(reset_hi),
	.undervolt_n(undervolt_n),
	.timeout_flag_n(timeout_flag_n)
);
`default_nettype wire
